/* nlec_defs.vh */
`ifndef NLEC_DEFS_VH
`define NLEC_DEFS_VH

// ************************************************************
// Widths of the link fields.
// ************************************************************
`define NLEC_SEQ_W 12
`define NLEC_LCRC_W 32
`define NLEC_LEN_W 10
`define NLEC_DWC_W 11
`define NLEC_CAUSE_W 5

// ************************************************************
// Sequence number arithmetic.
// ************************************************************
`define NLEC_SEQ_RST 12'h000
`define NLEC_SEQ_ONE 12'h001
`define NLEC_SEQ_HALF 12'h800
`define NLEC_ACKD_RST 12'hfff

// ************************************************************
// Packet type codes presented with each received packet.
// ************************************************************
`define NLEC_T_MRD 3'h0
`define NLEC_T_MWR 3'h1
`define NLEC_T_IORD 3'h2
`define NLEC_T_IOWR 3'h3
`define NLEC_T_CFGRD 3'h4
`define NLEC_T_CFGWR 3'h5
`define NLEC_T_CPL 3'h6
`define NLEC_T_MSG 3'h7

// ************************************************************
// Payload and packet size figures in doublewords.
// ************************************************************
`define NLEC_LEN_ONE 11'h001
`define NLEC_LEN_MAX 11'h400
`define NLEC_PAYLOAD_BASE 13'h0020
`define NLEC_RD_DW_CRC 11'h004
`define NLEC_RD_DW_NOCRC 11'h003
`define NLEC_WR_DW_CRC 11'h005
`define NLEC_WR_DW_NOCRC 11'h004

// ************************************************************
// Codes of the last error cause.
// ************************************************************
`define NLEC_C_NONE 5'h00
`define NLEC_C_SYMBOL 5'h01
`define NLEC_C_DISPARITY 5'h02
`define NLEC_C_DECODE 5'h03
`define NLEC_C_FRAMING 5'h04
`define NLEC_C_TRAINING 5'h05
`define NLEC_C_LCRC 5'h06
`define NLEC_C_SEQ 5'h07
`define NLEC_C_BAD_DLLP 5'h08
`define NLEC_C_REPLAY_TO 5'h09
`define NLEC_C_REPLAY_ROLL 5'h0a
`define NLEC_C_FC_INIT 5'h0b
`define NLEC_C_ACK_SEQ 5'h0c
`define NLEC_C_UNEXP_CPL 5'h0d
`define NLEC_C_MALFORMED 5'h0e

// ************************************************************
// Reset values of the mode strap path.
// ************************************************************
`define NLEC_MODE_RST 1'b0

`endif

/* nlec_sync.v */
`timescale 1ns/1ps
`default_nettype none
`include "nlec_defs.vh"

// ************************************************************
// Three stage pin synchroniser with agreement filter.
// ************************************************************
module nlec_sync (
  input wire clk,
  input wire rst_n,
  input wire pin_in,
  output reg level_out
);

  reg meta_r;
  reg s2_r;
  reg s3_r;

  // The first stage feeds only the second; the output moves once stages two and three agree.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= `NLEC_MODE_RST;
      s2_r <= `NLEC_MODE_RST;
      s3_r <= `NLEC_MODE_RST;
      level_out <= `NLEC_MODE_RST;
    end else begin
      meta_r <= pin_in;
      s2_r <= meta_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_out <= s3_r;
      end
    end
  end

endmodule
`default_nettype wire

/* nlec_malformed.v */
`timescale 1ns/1ps
`default_nettype none
`include "nlec_defs.vh"

// ************************************************************
// Malformed packet decode for one received header.
// ************************************************************
module nlec_malformed (
  input wire [2:0] tlp_type,
  input wire [`NLEC_LEN_W-1:0] tlp_len,
  input wire [2:0] tlp_tc,
  input wire [1:0] tlp_attr,
  input wire tlp_td,
  input wire [`NLEC_DWC_W-1:0] tlp_dw_cnt,
  input wire [2:0] max_payload_setting,
  output reg malformed
);

  reg [`NLEC_DWC_W-1:0] len_dw;
  reg [12:0] pay_dw;
  reg is_rd;
  reg is_wr;
  reg hdr_ok;

  // A zero length field stands for the largest payload.
  always @* begin
    len_dw = (tlp_len == {`NLEC_LEN_W{1'b0}}) ? `NLEC_LEN_MAX : {1'b0, tlp_len};
    pay_dw = `NLEC_PAYLOAD_BASE << max_payload_setting;
    is_rd = (tlp_type == `NLEC_T_IORD) || (tlp_type == `NLEC_T_CFGRD);
    is_wr = (tlp_type == `NLEC_T_IOWR) || (tlp_type == `NLEC_T_CFGWR);
    hdr_ok = (len_dw == `NLEC_LEN_ONE) && (tlp_tc == 3'h0) && (tlp_attr == 2'h0);
    malformed = 1'b0;
    if (!({2'h0, len_dw} < pay_dw)) begin
      malformed = 1'b1;
    end
    if (is_rd && !(hdr_ok && (tlp_dw_cnt == (tlp_td ? `NLEC_RD_DW_CRC : `NLEC_RD_DW_NOCRC)))) begin
      malformed = 1'b1;
    end
    if (is_wr && !(hdr_ok && (tlp_dw_cnt == (tlp_td ? `NLEC_WR_DW_CRC : `NLEC_WR_DW_NOCRC)))) begin
      malformed = 1'b1;
    end
  end

endmodule
`default_nettype wire

/* nlec_checker.v */
// Notes on behaviour
// - All error reports go to external root.
// - Link layer checks belong to external endpoint.
// - Symbol, disparity, decode, framing faults are correctable.
// - Training or initialisation breach is uncorrectable.
// - Nullified packet with inverted CRC drops silently.
// - Bad link CRC on packet is correctable.
// - Unexpected non-duplicate sequence number is correctable.
// - Bad control packet, replay expiry/wrap correctable.
// - Flow control initialisation breach is uncorrectable.
// - Acknowledge naming unknown sequence is uncorrectable.
// - End-to-end CRC is never checked here.
// - No flow control protocol or overflow checks.
// - No completer abort or time-out checks.
// - Only external endpoint faults are handled here.
// - Malformed received packet is fatal, receive only.
// - Length not below payload size is malformed.
// - I/O and config reads strictly shaped.
// - I/O and config writes strictly shaped.
`timescale 1ns/1ps
`default_nettype none
`include "nlec_defs.vh"

module nlec_checker (
  input wire clk,
  input wire rst_n,
  input wire nt_mode_pin,
  input wire [2:0] max_payload_setting,
  input wire phy_symbol_err,
  input wire phy_disparity_err,
  input wire phy_decode_err,
  input wire phy_framing_err,
  input wire phy_training_err,
  input wire tlp_end,
  input wire tlp_nullified,
  input wire [`NLEC_LCRC_W-1:0] tlp_lcrc_rx,
  input wire [`NLEC_LCRC_W-1:0] tlp_lcrc_calc,
  input wire [`NLEC_SEQ_W-1:0] tlp_seq,
  input wire [2:0] tlp_type,
  input wire [`NLEC_LEN_W-1:0] tlp_len,
  input wire [2:0] tlp_tc,
  input wire [1:0] tlp_attr,
  input wire tlp_td,
  input wire [`NLEC_DWC_W-1:0] tlp_dw_cnt,
  input wire dllp_end,
  input wire dllp_crc_bad,
  input wire replay_timeout,
  input wire replay_num_roll,
  input wire fc_init_err,
  input wire ack_valid,
  input wire [`NLEC_SEQ_W-1:0] ack_seq,
  input wire [`NLEC_SEQ_W-1:0] next_tx_seq,
  input wire cpl_unexpected,
  output reg ext_err_cor,
  output reg ext_err_nonfatal,
  output reg ext_err_fatal,
  output reg [`NLEC_CAUSE_W-1:0] ext_err_cause,
  output reg tlp_accept,
  output reg tlp_drop,
  output reg [`NLEC_SEQ_W-1:0] next_rcv_seq,
  output reg [`NLEC_SEQ_W-1:0] ackd_seq,
  output reg nt_mode
);

  // ************************************************************
  // Helper functions.
  // ************************************************************

  // Modulo distance from a reference sequence number to another.
  // The subtraction wraps at the field width, so the result stays a forward distance across rollover.
  function [`NLEC_SEQ_W-1:0] seq_dist;
    input [`NLEC_SEQ_W-1:0] from_seq;
    input [`NLEC_SEQ_W-1:0] to_seq;
    begin
      seq_dist = to_seq - from_seq;
    end
  endfunction

  // ************************************************************
  // Mode strap and malformed decode.
  // ************************************************************

  wire nt_mode_sync;
  wire tlp_malformed;

  // The mode strap arrives from a pin and is filtered before use.
  // Events that fall in the settling cycles of a strap change are judged under the old mode, not half reported.
  nlec_sync u_mode_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(nt_mode_pin),
    .level_out(nt_mode_sync)
  );

  // Header checks run on each packet as it ends at the receiving port.
  // Packets already inside the switch are never checked again.
  nlec_malformed u_malformed (
    .tlp_type(tlp_type),
    .tlp_len(tlp_len),
    .tlp_tc(tlp_tc),
    .tlp_attr(tlp_attr),
    .tlp_td(tlp_td),
    .tlp_dw_cnt(tlp_dw_cnt),
    .max_payload_setting(max_payload_setting),
    .malformed(tlp_malformed)
  );

  // ************************************************************
  // Data link layer packet disposition.
  // ************************************************************

  reg lcrc_good;
  reg lcrc_inverted;
  reg seq_match;
  reg seq_duplicate;
  reg pkt_silent_drop;
  reg pkt_lcrc_err;
  reg pkt_seq_err;
  reg pkt_good;
  reg pkt_fatal;

  // Classify an ending packet into accept, silent drop or error.
  // A nullified packet is judged first: its CRC, if inverted, is spoiled on purpose and is no CRC fault.
  // Only a packet with good CRC and the expected number reaches the header checks,
  // so a malformed header is never blamed on a packet that was damaged on the wire.
  always @* begin
    lcrc_good = (tlp_lcrc_rx == tlp_lcrc_calc);
    lcrc_inverted = (tlp_lcrc_rx == ~tlp_lcrc_calc);
    seq_match = (tlp_seq == next_rcv_seq);
    seq_duplicate = !seq_match && (seq_dist(tlp_seq, next_rcv_seq) <= `NLEC_SEQ_HALF);
    pkt_silent_drop = 1'b0;
    pkt_lcrc_err = 1'b0;
    pkt_seq_err = 1'b0;
    pkt_good = 1'b0;
    pkt_fatal = 1'b0;
    if (tlp_end) begin
      if (tlp_nullified) begin
        pkt_silent_drop = lcrc_inverted;
        pkt_lcrc_err = !lcrc_inverted;
      end else if (!lcrc_good) begin
        pkt_lcrc_err = 1'b1;
      end else if (seq_match) begin
        pkt_good = 1'b1;
        pkt_fatal = tlp_malformed;
      end else if (seq_duplicate) begin
        pkt_silent_drop = 1'b1;
      end else begin
        pkt_seq_err = 1'b1;
      end
    end
  end

  // ************************************************************
  // Acknowledge sequence check.
  // ************************************************************

  reg ack_known;
  reg ack_bad;
  reg ack_advance;

  // An acknowledge must name the last acknowledged or an outstanding packet.
  // Outstanding packets lie between the last acknowledged number and the next to be sent.
  // Both distances are taken from the last acknowledged number, so the window may wrap.
  always @* begin
    ack_known = (ack_seq == ackd_seq) ||
                (seq_dist(ackd_seq, ack_seq) < seq_dist(ackd_seq, next_tx_seq));
    ack_bad = ack_valid && !ack_known;
    ack_advance = ack_valid && ack_known && (ack_seq != ackd_seq);
  end

  // ************************************************************
  // Error classification.
  // ************************************************************

  reg any_cor;
  reg any_uncor;
  reg [`NLEC_CAUSE_W-1:0] cause_nxt;

  // Gather the events of each class; the cause names the most severe one.
  // Several events may fall in one cycle; the class outputs carry only the gravest,
  // and the cause follows the same order so that it always matches the class shown.
  always @* begin
    any_cor = phy_symbol_err || phy_disparity_err || phy_decode_err || phy_framing_err;
    any_cor = any_cor || pkt_lcrc_err || pkt_seq_err;
    any_cor = any_cor || (dllp_end && dllp_crc_bad) || replay_timeout || replay_num_roll;
    any_uncor = phy_training_err || fc_init_err || ack_bad || cpl_unexpected;
    cause_nxt = `NLEC_C_NONE;
    if (pkt_fatal) begin
      cause_nxt = `NLEC_C_MALFORMED;
    end else if (phy_training_err) begin
      cause_nxt = `NLEC_C_TRAINING;
    end else if (fc_init_err) begin
      cause_nxt = `NLEC_C_FC_INIT;
    end else if (ack_bad) begin
      cause_nxt = `NLEC_C_ACK_SEQ;
    end else if (cpl_unexpected) begin
      cause_nxt = `NLEC_C_UNEXP_CPL;
    end else if (phy_symbol_err) begin
      cause_nxt = `NLEC_C_SYMBOL;
    end else if (phy_disparity_err) begin
      cause_nxt = `NLEC_C_DISPARITY;
    end else if (phy_decode_err) begin
      cause_nxt = `NLEC_C_DECODE;
    end else if (phy_framing_err) begin
      cause_nxt = `NLEC_C_FRAMING;
    end else if (pkt_lcrc_err) begin
      cause_nxt = `NLEC_C_LCRC;
    end else if (pkt_seq_err) begin
      cause_nxt = `NLEC_C_SEQ;
    end else if (dllp_end && dllp_crc_bad) begin
      cause_nxt = `NLEC_C_BAD_DLLP;
    end else if (replay_timeout) begin
      cause_nxt = `NLEC_C_REPLAY_TO;
    end else if (replay_num_roll) begin
      cause_nxt = `NLEC_C_REPLAY_ROLL;
    end
  end

  // End-to-end CRC of consumed packets, receiver overflow, flow control protocol,
  // completer abort and completion time-out have no input here and raise nothing.

  // ************************************************************
  // Next values of the reports.
  // ************************************************************

  reg fatal_nxt;
  reg nonfatal_nxt;
  reg cor_nxt;
  reg accept_nxt;
  reg drop_nxt;
  reg cause_load;

  // Only the most severe class pulses when several fire together.
  // While the port runs transparent the link layers belong to the other side,
  // so every report stays quiet and the last cause is kept for software.
  always @* begin
    fatal_nxt = 1'b0;
    nonfatal_nxt = 1'b0;
    cor_nxt = 1'b0;
    accept_nxt = 1'b0;
    drop_nxt = 1'b0;
    cause_load = 1'b0;
    if (nt_mode_sync) begin
      fatal_nxt = pkt_fatal;
      nonfatal_nxt = !pkt_fatal && any_uncor;
      cor_nxt = !pkt_fatal && !any_uncor && any_cor;
      accept_nxt = pkt_good && !pkt_fatal;
      drop_nxt = tlp_end && !accept_nxt;
      cause_load = (cause_nxt != `NLEC_C_NONE);
    end
  end

  // ************************************************************
  // Registered reports toward the external root.
  // ************************************************************

  // Every report leaves from a flip-flop, one cycle after the event it names.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_err_cor <= 1'b0;
      ext_err_nonfatal <= 1'b0;
      ext_err_fatal <= 1'b0;
      ext_err_cause <= `NLEC_C_NONE;
      tlp_accept <= 1'b0;
      tlp_drop <= 1'b0;
      nt_mode <= `NLEC_MODE_RST;
    end else begin
      nt_mode <= nt_mode_sync;
      ext_err_fatal <= fatal_nxt;
      ext_err_nonfatal <= nonfatal_nxt;
      ext_err_cor <= cor_nxt;
      tlp_accept <= accept_nxt;
      tlp_drop <= drop_nxt;
      if (cause_load) begin
        ext_err_cause <= cause_nxt;
      end
    end
  end

  // ************************************************************
  // Receive and acknowledge sequence state.
  // ************************************************************

  // The expected receive number moves on each packet passing link checks.
  // A malformed packet still moves it: the link layer took the packet, and the fault
  // belongs to the transaction layer, which reports it as fatal instead.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      next_rcv_seq <= `NLEC_SEQ_RST;
      ackd_seq <= `NLEC_ACKD_RST;
    end else if (nt_mode_sync) begin
      if (pkt_good) begin
        next_rcv_seq <= next_rcv_seq + `NLEC_SEQ_ONE;
      end
      if (ack_advance) begin
        ackd_seq <= ack_seq;
      end
    end
  end

endmodule
`default_nettype wire

/* nlec_checker_sva.sv */
`timescale 1ns/1ps
`default_nettype none
`include "nlec_defs.vh"
// ************
// Port checker for the link error classifier.
// ************
module nlec_checker_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic nt_mode,
  input wire logic phy_symbol_err,
  input wire logic phy_training_err,
  input wire logic fc_init_err,
  input wire logic ack_valid,
  input wire logic cpl_unexpected,
  input wire logic tlp_end,
  input wire logic tlp_nullified,
  input wire logic [`NLEC_LCRC_W-1:0] tlp_lcrc_rx,
  input wire logic [`NLEC_LCRC_W-1:0] tlp_lcrc_calc,
  input wire logic ext_err_cor,
  input wire logic ext_err_nonfatal,
  input wire logic ext_err_fatal,
  input wire logic [`NLEC_CAUSE_W-1:0] ext_err_cause,
  input wire logic tlp_accept,
  input wire logic tlp_drop
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Each report lands in one class and only while bridged.
  a_one_class: assert property ($onehot0({ext_err_cor, ext_err_nonfatal, ext_err_fatal}))
    else $error("two classes");
  a_off_quiet: assert property (!nt_mode |-> !(ext_err_cor || ext_err_nonfatal || ext_err_fatal))
    else $error("report while transparent");
  // Physical and link events map to their class and cause.
  a_sym_cor: assert property (nt_mode && phy_symbol_err && !phy_training_err && !fc_init_err &&
    !ack_valid && !cpl_unexpected && !tlp_end |=> ext_err_cor && ext_err_cause == `NLEC_C_SYMBOL)
    else $error("symbol fault class");
  a_unc_cls: assert property (nt_mode && (phy_training_err || fc_init_err) && !tlp_end |=>
    ext_err_nonfatal && ext_err_cause == ($past(phy_training_err) ? `NLEC_C_TRAINING : `NLEC_C_FC_INIT))
    else $error("uncorrectable class");
  // Packet disposition against the CRC pair.
  a_null_drop: assert property (nt_mode && tlp_end && tlp_nullified && tlp_lcrc_rx == ~tlp_lcrc_calc
    |=> tlp_drop && !tlp_accept && !ext_err_fatal)
    else $error("nullified not dropped");
  a_crc_err: assert property (nt_mode && tlp_end && !tlp_nullified && tlp_lcrc_rx != tlp_lcrc_calc
    |=> tlp_drop && (ext_err_cor || ext_err_nonfatal))
    else $error("bad CRC not reported");
  a_accept_src: assert property (tlp_accept |-> $past(tlp_end) && !$past(tlp_nullified) &&
    $past(tlp_lcrc_rx) == $past(tlp_lcrc_calc) && !tlp_drop)
    else $error("accept without clean packet");
  a_fatal_mal: assert property (ext_err_fatal |-> tlp_drop && $past(tlp_end) &&
    ext_err_cause == `NLEC_C_MALFORMED)
    else $error("fatal without malformed packet");
  c_fatal: cover property (ext_err_fatal);
  c_accept: cover property (tlp_accept);
  c_nonfatal: cover property (ext_err_nonfatal);
endmodule
`default_nettype wire

/* nlec_root_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ************
// Far-end partner that frames packets.
// ************
module nlec_root_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [1:0] crp,
  input wire logic [11:0] off,
  output logic tlp_end,
  output logic tlp_nullified,
  output logic [31:0] lcrc_rx,
  output logic [31:0] lcrc_calc,
  output logic [11:0] seq
);
  logic [11:0] seq_r;
  logic [31:0] pat_r;
  // The sequence moves on only after a clean new packet, so a damaged one is sent again.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_r <= 12'h000;
      pat_r <= 32'h0000_0001;
    end else begin
      pat_r <= pat_r + 32'h9e37_79b9;
      if (go && crp == 2'h0 && off == 12'h000) seq_r <= seq_r + 12'h001;
    end
  end
  // Code 0 good, 1 bad CRC, 2 nullified with inverted CRC, 3 nullified with plain CRC.
  assign tlp_end = go;
  assign tlp_nullified = go ? crp[1] : pat_r[3];
  assign lcrc_calc = pat_r;
  assign lcrc_rx = (!go || crp == 2'h2) ? ~pat_r : pat_r ^ {31'h0000_0000, crp == 2'h1};
  assign seq = go ? seq_r + off : ~seq_r;
endmodule
`default_nettype wire

/* nlec_checker_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "nlec_defs.vh"
// ************
// Self-checking bench for the link error classifier.
// ************
module nlec_checker_test;
  logic clk = 1'b0, rst_n = 1'b0, pin = 1'b1, td = 1'b0, go = 1'b0;
  logic [1:0] crp = 2'h0, at = 2'h0;
  logic [2:0] pay_code = 3'h0, ty = 3'h0, tc = 3'h0;
  logic [9:0] len = 10'h001;
  logic [10:0] dw = 11'h003, evv = 11'h000;
  logic [11:0] off = 12'h000, aseq = 12'h000, ntx = 12'h000, xs = 12'h000;
  logic [4:0] lc = 5'h00;
  wire t_end, t_null, o_cor, o_nf, o_fat, o_acc, o_drop, o_mode;
  wire [31:0] crx, ccal;
  wire [11:0] tseq, o_nrs, o_ackd;
  wire [4:0] o_cause;
  int failures = 0;
  int cmp_count = 0;
  localparam logic [4:0] ev_c [10] = '{`NLEC_C_SYMBOL, `NLEC_C_DISPARITY, `NLEC_C_DECODE, `NLEC_C_FRAMING,
    `NLEC_C_TRAINING, `NLEC_C_BAD_DLLP, `NLEC_C_REPLAY_TO, `NLEC_C_REPLAY_ROLL, `NLEC_C_FC_INIT, `NLEC_C_UNEXP_CPL};
  // Clock at 4 ns.
  always #2 clk = ~clk;
  nlec_root_model root (.clk(clk), .rst_n(rst_n), .go(go), .crp(crp), .off(off), .tlp_end(t_end),
    .tlp_nullified(t_null), .lcrc_rx(crx), .lcrc_calc(ccal), .seq(tseq));
  nlec_checker uut (.clk(clk), .rst_n(rst_n), .nt_mode_pin(pin), .max_payload_setting(pay_code),
    .phy_symbol_err(evv[0]), .phy_disparity_err(evv[1]), .phy_decode_err(evv[2]), .phy_framing_err(evv[3]),
    .phy_training_err(evv[4]), .tlp_end(t_end), .tlp_nullified(t_null), .tlp_lcrc_rx(crx), .tlp_lcrc_calc(ccal),
    .tlp_seq(tseq), .tlp_type(ty), .tlp_len(len), .tlp_tc(tc), .tlp_attr(at), .tlp_td(td), .tlp_dw_cnt(dw),
    .dllp_end(evv[5]), .dllp_crc_bad(evv[5]), .replay_timeout(evv[6]), .replay_num_roll(evv[7]),
    .fc_init_err(evv[8]), .cpl_unexpected(evv[9]), .ack_valid(evv[10]), .ack_seq(aseq), .next_tx_seq(ntx),
    .ext_err_cor(o_cor), .ext_err_nonfatal(o_nf), .ext_err_fatal(o_fat), .ext_err_cause(o_cause),
    .tlp_accept(o_acc), .tlp_drop(o_drop), .next_rcv_seq(o_nrs), .ackd_seq(o_ackd), .nt_mode(o_mode));
  // Verdict and end of run.
  task automatic end_sim;
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Compares the class pulses, disposition and cause as one word.
  task automatic chk_out(input logic [9:0] e);
    cmp_count++;
    if (e[9:7] != 3'h0) lc = e[4:0];
    if ({o_cor, o_nf, o_fat, o_drop, o_acc, o_cause} !== e) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, {o_cor, o_nf, o_fat, o_drop, o_acc, o_cause}, e);
    end
  endtask
  // Compares a sequence or mode value.
  task automatic chk_val(input logic [11:0] g, input logic [11:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t value %h want %h", $time, g, e);
    end
  endtask
  // Works out whether a header is malformed for the current payload code.
  function automatic logic mal(input logic [2:0] t, input logic [9:0] l, input logic [2:0] q,
    input logic [1:0] a, input logic d, input logic [10:0] n);
    int ld;
    ld = (l == 10'h000) ? 1024 : int'(l);
    if (ld >= (32 << pay_code)) return 1'b1;
    if (t >= 3'h2 && t <= 3'h5) return !(l == 10'h001 && q == 3'h0 && a == 2'h0 && n == 11'h003 + t[0] + d);
    return 1'b0;
  endfunction
  // Pulses link events for one cycle and waits for the answer.
  task automatic fire(input logic [10:0] e);
    @(posedge clk);
    evv <= e;
    @(posedge clk);
    evv <= 11'h000;
    #1;
  endtask
  // Sends one packet through the partner and checks its disposition.
  task automatic pkt(input logic [1:0] c, input logic [11:0] o, input logic [2:0] t, input logic [9:0] l,
    input logic [2:0] q, input logic [1:0] a, input logic d, input logic [10:0] n);
    logic m;
    @(posedge clk);
    m = mal(t, l, q, a, d, n);
    {crp, off, ty, len, tc, at, td, dw, go} <= {c, o, t, l, q, a, d, n, 1'b1};
    @(posedge clk);
    go <= 1'b0;
    #1;
    if (c == 2'h2 || (c == 2'h0 && o[11])) chk_out({5'h02, lc});
    else if (c != 2'h0) chk_out({5'h12, `NLEC_C_LCRC});
    else if (o != 12'h000) chk_out({5'h12, `NLEC_C_SEQ});
    else begin
      xs = xs + 12'h001;
      chk_out(m ? {5'h06, `NLEC_C_MALFORMED} : {5'h01, lc});
    end
    chk_val(o_nrs, xs);
  endtask
  // Strap change, with the filter given a fixed settling span.
  task automatic set_mode(input logic v);
    @(posedge clk);
    pin <= v;
    repeat (12) @(posedge clk);
    #1;
    chk_val({11'h000, o_mode}, {11'h000, v});
  endtask
  // Watchdog far beyond the expected run.
  initial begin
    #100000;
    failures++;
    $display("BAD %0t watchdog expired", $time);
    end_sim();
  end
  // Main sequence: corners first, then random packets.
  initial begin
    void'($urandom(32'h791a));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    set_mode(1'b1);
    pkt(2'h0, 12'h000, `NLEC_T_IORD, 10'h001, 3'h0, 2'h0, 1'b0, 11'h003);
    pkt(2'h0, 12'h000, `NLEC_T_IORD, 10'h001, 3'h0, 2'h0, 1'b0, 11'h004);
    pkt(2'h0, 12'h000, `NLEC_T_IOWR, 10'h001, 3'h0, 2'h0, 1'b1, 11'h005);
    pkt(2'h0, 12'h000, `NLEC_T_CFGWR, 10'h001, 3'h0, 2'h1, 1'b0, 11'h004);
    pkt(2'h0, 12'h000, `NLEC_T_CFGRD, 10'h001, 3'h1, 2'h0, 1'b1, 11'h004);
    pkt(2'h0, 12'h000, `NLEC_T_MWR, 10'h01f, 3'h0, 2'h0, 1'b0, 11'h022);
    pkt(2'h0, 12'h000, `NLEC_T_MWR, 10'h020, 3'h0, 2'h0, 1'b0, 11'h023);
    for (int c = 1; c < 4; c++) pkt(2'(c), 12'h000, `NLEC_T_MRD, 10'h001, 3'h0, 2'h0, 1'b0, 11'h003);
    pkt(2'h0, 12'h003, `NLEC_T_MRD, 10'h001, 3'h0, 2'h0, 1'b0, 11'h003);
    pkt(2'h0, 12'hfff, `NLEC_T_MRD, 10'h001, 3'h0, 2'h0, 1'b0, 11'h003);
    for (int i = 0; i < 10; i++) begin
      fire(11'h001 << i);
      chk_out({(i == 4 || i > 7) ? 5'h08 : 5'h10, ev_c[i]});
    end
    fire(11'h011);
    chk_out({5'h08, `NLEC_C_TRAINING});
    @(posedge clk);
    {ntx, aseq} <= {12'h005, 12'h003};
    repeat (2) begin
      fire(11'h400);
      chk_out({5'h00, lc});
    end
    chk_val(o_ackd, 12'h003);
    @(posedge clk);
    aseq <= 12'h009;
    fire(11'h400);
    chk_out({5'h08, `NLEC_C_ACK_SEQ});
    for (int k = 0; k < 80; k++) begin
      @(posedge clk);
      pay_code <= 3'($urandom % 6);
      pkt(($urandom % 2) ? 2'h0 : 2'($urandom), ($urandom % 4) ? 12'h000 : 12'($urandom), 3'($urandom),
        ($urandom % 3) ? 10'h001 : 10'($urandom), 3'($urandom % 8 == 0), 2'($urandom % 8 == 0),
        1'($urandom), 11'(3 + $urandom % 3));
    end
    set_mode(1'b0);
    fire(11'h001);
    chk_out({5'h00, lc});
    end_sim();
  end
endmodule
bind nlec_checker nlec_checker_sva sva (.clk(clk), .rst_n(rst_n), .nt_mode(nt_mode),
  .phy_symbol_err(phy_symbol_err), .phy_training_err(phy_training_err), .fc_init_err(fc_init_err),
  .ack_valid(ack_valid), .cpl_unexpected(cpl_unexpected), .tlp_end(tlp_end), .tlp_nullified(tlp_nullified),
  .tlp_lcrc_rx(tlp_lcrc_rx), .tlp_lcrc_calc(tlp_lcrc_calc), .ext_err_cor(ext_err_cor),
  .ext_err_nonfatal(ext_err_nonfatal), .ext_err_fatal(ext_err_fatal), .ext_err_cause(ext_err_cause),
  .tlp_accept(tlp_accept), .tlp_drop(tlp_drop));
`default_nettype wire
